// [src/cgs_clock_gen.v]
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "cgs_regs.vh"
module cgs_clock_gen #(
  parameter           VSTAB_CYC    = `CGS_VSTAB_CYC,
  parameter           FASTRISE_CYC = `CGS_FASTRISE_CYC,
  parameter           CNT_W        = 20
) (
  // clock and reset
  input  wire         clock,
  input  wire         rst,
  // register port
  input  wire [3:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [7:0]   reg_rdata,
  // option byte and supply comparators
  input  wire         por_threshold_option,
  input  wire         lowspeed_stoppable_opt,
  input  wire         wdt_enable_opt,
  input  wire         supply_above_low,
  input  wire         supply_above_high,
  // standby from the cpu
  input  wire         stop_exec,
  input  wire         stop_wake,
  output wire         standby,
  // high-speed system clock pins
  input  wire         crystal_pin_a,
  input  wire         ext_clock_pin,
  output wire         crystal_pin_a_port_mode,
  output wire         crystal_pin_b_port_mode,
  output wire         osc_amp_enable,
  // reset and clock enables
  output wire         internal_reset,
  output wire         hs_int_tick,
  output wire         hs_sys_clk_tick,
  output wire         main_tick,
  output reg          cpu_tick_q,
  output reg  [4:0]   periph_tick_q,
  output wire         wdt_tick,
  output wire         timer8_tick,
  output wire         cpu_on_hs
);
  localparam [1:0] P_HOLD = 2'd0;
  localparam [1:0] P_STAB = 2'd1;
  localparam [1:0] P_RUN  = 2'd2;

  localparam [63:0] HSI_INC64 = 64'd`CGS_HSI_KHZ * (64'd1 << `CGS_NCO_W) / 64'd`CGS_CLK_KHZ;
  localparam [63:0] LSI_INC64 = 64'd`CGS_LSI_KHZ * (64'd1 << `CGS_NCO_W) / 64'd`CGS_CLK_KHZ;
  localparam integer     VSTAB_LAST_I = VSTAB_CYC - 1;
  localparam integer     FASTRISE_I   = FASTRISE_CYC;
  localparam [CNT_W-1:0] VSTAB_LAST   = VSTAB_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] FASTRISE_N   = FASTRISE_I[CNT_W-1:0];

  reg  [1:0]       por_q;
  reg  [CNT_W-1:0] por_cnt_q;
  reg  [1:0]       rcm_q;
  reg              hs_osc_stop_bit_q;
  reg  [1:0]       pin_q;
  reg  [2:0]       osc_settle_select_reg_q;
  reg              req_hs_q;
  reg  [2:0]       pcc_q;
  reg              stop_q;
  reg  [16:0]      settle_q;
  reg              pin_prev_q;
  reg              sel_q;
  reg              gap_q;
  reg  [3:0]       div_q;
  reg  [7:0]       rd_d;

  wire             por_hold;
  wire             hsi_en;
  wire             lsi_en;
  wire             lsi_tick;
  wire             hs_src;
  wire             hs_on;
  wire             ext_mode;
  wire             hs_ready;
  wire [4:0]       settle_status;
  wire             cur_tick;
  wire             want_switch;
  wire             cpu_ok;
  wire [4:0]       pre;

  // settle count limit for a wait-select code
  function [16:0] settle_limit;
    input [2:0] code;
    begin
      case (code)
        3'h1:    settle_limit = 17'h00800;
        3'h2:    settle_limit = 17'h02000;
        3'h3:    settle_limit = 17'h04000;
        3'h4:    settle_limit = 17'h08000;
        default: settle_limit = 17'h10000;
      endcase
    end
  endfunction

  // settle status bits, first threshold in the top bit
  function [4:0] settle_bits;
    input [16:0] cnt;
    begin
      settle_bits = {cnt >= settle_limit(3'h1), cnt >= settle_limit(3'h2),
                     cnt >= settle_limit(3'h3), cnt >= settle_limit(3'h4),
                     cnt >= settle_limit(3'h5)};
    end
  endfunction

  // power-on-clear sequencing
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      por_q     <= P_HOLD;
      por_cnt_q <= {CNT_W{1'b0}};
    end
    else if (!supply_above_low)
    begin
      por_q     <= P_HOLD;
      por_cnt_q <= {CNT_W{1'b0}};
    end
    else
    begin
      if (por_cnt_q != {CNT_W{1'b1}})
        por_cnt_q <= por_cnt_q + 1'b1;
      case (por_q)
        P_HOLD:
        begin
          if (!por_threshold_option)
            por_q <= P_STAB;
          else if (supply_above_high)
            por_q <= (por_cnt_q < FASTRISE_N) ? P_STAB : P_RUN;
        end
        P_STAB:
        begin
          if (por_cnt_q >= VSTAB_LAST)
            por_q <= P_RUN;
        end
        P_RUN:
          por_q <= P_RUN;
        default:
          por_q <= P_HOLD;
      endcase
    end
  end

  assign por_hold       = (por_q == P_HOLD);
  assign internal_reset = (por_q != P_RUN);

  // oscillators as enable pulses
  assign hsi_en = !por_hold && !rcm_q[`CGS_BIT_HSI_STOP] && !stop_q;
  assign lsi_en = !por_hold &&
                  !(lowspeed_stoppable_opt && rcm_q[`CGS_BIT_LSI_STOP]);

  cgs_nco #(.ACC_W(`CGS_NCO_W), .INC(HSI_INC64[`CGS_NCO_W-1:0])) u_hsi (
    .clock  (clock),
    .rst    (rst),
    .enable (hsi_en),
    .tick_q (hs_int_tick)
  );

  cgs_nco #(.ACC_W(`CGS_NCO_W), .INC(LSI_INC64[`CGS_NCO_W-1:0])) u_lsi (
    .clock  (clock),
    .rst    (rst),
    .enable (lsi_en),
    .tick_q (lsi_tick)
  );

  // low-speed clock goes nowhere else
  assign wdt_tick    = lsi_tick & wdt_enable_opt;
  assign timer8_tick = lsi_tick;

  // high-speed system clock pins
  assign ext_mode = pin_q[`CGS_BIT_PIN_EXT_SEL];
  assign hs_on    = pin_q[`CGS_BIT_PIN_OSC_SEL] && !hs_osc_stop_bit_q && !stop_q;
  assign hs_src   = ext_mode ? ext_clock_pin : crystal_pin_a;
  assign hs_sys_clk_tick = hs_on && hs_src && !pin_prev_q;
  assign osc_amp_enable  = hs_on && !ext_mode;
  assign crystal_pin_a_port_mode = !pin_q[`CGS_BIT_PIN_OSC_SEL] || ext_mode;
  assign crystal_pin_b_port_mode = !pin_q[`CGS_BIT_PIN_OSC_SEL];

  // settle status, external clock needs no wait
  assign settle_status = ext_mode ? 5'h1f : settle_bits(settle_q);
  assign hs_ready      = ext_mode || (settle_q >= settle_limit(osc_settle_select_reg_q));

  // glitch-free cpu source switch
  assign cur_tick    = sel_q ? hs_sys_clk_tick : hs_int_tick;
  assign want_switch = (req_hs_q != sel_q) && (req_hs_q ? hs_ready : hsi_en);
  assign cpu_ok      = !internal_reset && !stop_q && !(sel_q && !hs_ready);
  assign cpu_on_hs   = sel_q;
  assign standby     = stop_q;

  // prescaler taps
  assign pre[0]    = cur_tick && !gap_q && cpu_ok;
  assign main_tick = pre[0];
  genvar k;
  generate
    for (k = 1; k < 5; k = k + 1)
    begin : g_pre
      assign pre[k] = pre[k-1] & div_q[k-1];
    end
  endgenerate

  // clock-domain state
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stop_q        <= 1'b0;
      settle_q      <= 17'h00000;
      pin_prev_q    <= 1'b0;
      sel_q         <= 1'b0;
      gap_q         <= 1'b0;
      div_q         <= 4'h0;
      cpu_tick_q    <= 1'b0;
      periph_tick_q <= 5'h00;
    end
    else if (por_hold)
    begin
      stop_q        <= 1'b0;
      settle_q      <= 17'h00000;
      sel_q         <= 1'b0;
      gap_q         <= 1'b0;
      div_q         <= 4'h0;
      cpu_tick_q    <= 1'b0;
      periph_tick_q <= 5'h00;
    end
    else
    begin
      pin_prev_q <= hs_src;
      if (stop_exec)
        stop_q <= 1'b1;
      else if (stop_wake)
        stop_q <= 1'b0;
      if (stop_exec || hs_osc_stop_bit_q)
        settle_q <= 17'h00000;
      else if (hs_sys_clk_tick && settle_q < settle_limit(osc_settle_select_reg_q))
        settle_q <= settle_q + 17'h00001;
      if (gap_q && cur_tick)
        gap_q <= 1'b0;
      else if (want_switch && cur_tick && !gap_q)
      begin
        sel_q <= !sel_q;
        gap_q <= 1'b1;
      end
      if (pre[0])
        div_q <= div_q + 4'h1;
      cpu_tick_q    <= pre[pcc_q];
      periph_tick_q <= pre;
    end
  end

  // software registers
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rcm_q    <= `CGS_RST_INT_OSC_MODE;
      hs_osc_stop_bit_q  <= `CGS_RST_HS_OSC_STOP;
      pin_q    <= `CGS_RST_PIN_MODE;
      osc_settle_select_reg_q   <= `CGS_RST_SETTLE_SELECT;
      req_hs_q <= 1'b0;
      pcc_q    <= `CGS_RST_CPU_DIV;
    end
    else if (por_hold)
    begin
      rcm_q    <= `CGS_RST_INT_OSC_MODE;
      hs_osc_stop_bit_q  <= `CGS_RST_HS_OSC_STOP;
      pin_q    <= `CGS_RST_PIN_MODE;
      osc_settle_select_reg_q   <= `CGS_RST_SETTLE_SELECT;
      req_hs_q <= 1'b0;
      pcc_q    <= `CGS_RST_CPU_DIV;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `CGS_OFS_INT_OSC_MODE:
        begin
          // a stop of the clock now feeding the cpu is ignored
          if (sel_q || !reg_wdata[`CGS_BIT_HSI_STOP])
            rcm_q[`CGS_BIT_HSI_STOP] <= reg_wdata[`CGS_BIT_HSI_STOP];
          rcm_q[`CGS_BIT_LSI_STOP] <= reg_wdata[`CGS_BIT_LSI_STOP];
        end
        `CGS_OFS_HS_OSC_CTRL:
        begin
          if (!sel_q || !reg_wdata[`CGS_BIT_HS_OSC_STOP])
            hs_osc_stop_bit_q <= reg_wdata[`CGS_BIT_HS_OSC_STOP];
        end
        `CGS_OFS_SETTLE_SELECT:
        begin
          if (reg_wdata[2:0] >= 3'h1 && reg_wdata[2:0] <= 3'h5)
            osc_settle_select_reg_q <= reg_wdata[2:0];
        end
        `CGS_OFS_PIN_MODE:
        begin
          // pin mode frozen while the high-speed clock runs
          if (hs_osc_stop_bit_q)
            pin_q <= reg_wdata[1:0];
        end
        `CGS_OFS_CLOCK_SELECT:
        begin
          req_hs_q <= reg_wdata[`CGS_BIT_REQ_HS];
          if (reg_wdata[3:1] <= `CGS_MAX_CPU_DIV)
            pcc_q <= reg_wdata[3:1];
        end
        default:
          rcm_q <= rcm_q;
      endcase
    end
  end

  // read mux
  always @*
  begin
    rd_d = 8'h00;
    case (reg_addr)
      `CGS_OFS_INT_OSC_MODE:  rd_d = {6'h00, rcm_q};
      `CGS_OFS_HS_OSC_CTRL:   rd_d = {hs_osc_stop_bit_q, 7'h00};
      `CGS_OFS_SETTLE_STATUS: rd_d = {3'h0, settle_status};
      `CGS_OFS_SETTLE_SELECT: rd_d = {5'h00, osc_settle_select_reg_q};
      `CGS_OFS_PIN_MODE:      rd_d = {6'h00, pin_q};
      `CGS_OFS_CLOCK_SELECT:  rd_d = {sel_q, 3'h0, pcc_q, req_hs_q};
      `CGS_OFS_STATUS:        rd_d = {4'h0, hs_on, hs_ready, internal_reset, stop_q};
      default:                rd_d = 8'h00;
    endcase
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_d;
    else
      reg_rdata <= 8'h00;
  end
endmodule

// [src/cgs_regs.vh]
`ifndef CGS_REGS_VH
`define CGS_REGS_VH

// register offsets (index on the register port)
`define CGS_OFS_INT_OSC_MODE    4'h0
`define CGS_OFS_HS_OSC_CTRL     4'h1
`define CGS_OFS_SETTLE_STATUS   4'h2
`define CGS_OFS_SETTLE_SELECT   4'h3
`define CGS_OFS_PIN_MODE        4'h4
`define CGS_OFS_CLOCK_SELECT    4'h5
`define CGS_OFS_STATUS          4'h6

// field positions
`define CGS_BIT_HSI_STOP        0
`define CGS_BIT_LSI_STOP        1
`define CGS_BIT_HS_OSC_STOP     7
`define CGS_BIT_PIN_OSC_SEL     0
`define CGS_BIT_PIN_EXT_SEL     1
`define CGS_BIT_REQ_HS          0
`define CGS_BIT_CPU_ON_HS       7

// reset values, and the largest cpu divider code
`define CGS_RST_INT_OSC_MODE    2'h0
`define CGS_RST_HS_OSC_STOP     1'h1
`define CGS_RST_SETTLE_STATUS   5'h00
`define CGS_RST_SETTLE_SELECT   3'h5
`define CGS_RST_PIN_MODE        2'h0
`define CGS_RST_CPU_DIV         3'h1
`define CGS_MAX_CPU_DIV         3'h4

// oscillator rates and system clock, in kHz, and the divider accumulator width
`define CGS_CLK_KHZ             100000
`define CGS_HSI_KHZ             8000
`define CGS_LSI_KHZ             240
`define CGS_NCO_W               20

// supply timing, in microseconds, and derived cycles at 100 MHz
`define CGS_CLK_MHZ             100
`define CGS_VSTAB_US            5390
`define CGS_FASTRISE_US         1930
`define CGS_VSTAB_CYC           (`CGS_VSTAB_US * `CGS_CLK_MHZ)
`define CGS_FASTRISE_CYC        (`CGS_FASTRISE_US * `CGS_CLK_MHZ)

`endif

// [src/cgs_nco.v]
`timescale 1ns/1ns
// fractional divider: one-cycle enable pulse at INC/2^ACC_W of the clock rate
module cgs_nco #(
  parameter                ACC_W = 20,
  parameter [ACC_W-1:0]    INC   = 1
) (
  // clock and reset
  input  wire              clock,
  input  wire              rst,
  // control
  input  wire              enable,
  output reg               tick_q
);
  reg  [ACC_W-1:0] acc_q;
  wire [ACC_W:0]   sum_d;

  assign sum_d = {1'b0, acc_q} + {1'b0, INC};

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      acc_q  <= {ACC_W{1'b0}};
      tick_q <= 1'b0;
    end
    else if (enable)
    begin
      acc_q  <= sum_d[ACC_W-1:0];
      tick_q <= sum_d[ACC_W];
    end
    else
    begin
      tick_q <= 1'b0;
    end
  end
endmodule

// [test/cgs_clock_source.sv]
`timescale 1ns/1ns
// resonator and external oscillator seen as synchronous pin levels
module cgs_clock_source #(
  parameter HALF = 2
) (
  // clock
  input  wire clock,
  // control
  input  wire osc_amp_enable,
  input  wire ext_enable,
  // pins
  output reg  crystal_pin_a,
  output reg  ext_clock_pin
);
  integer cnt_q = 0;
  initial crystal_pin_a = 1'b0;
  initial ext_clock_pin = 1'b0;
  always @(posedge clock)
  begin
    cnt_q <= (cnt_q + 1) % HALF;
    // resonator swings only while its amplifier runs
    if (!osc_amp_enable)
      crystal_pin_a <= 1'b0;
    else if (cnt_q == 0)
      crystal_pin_a <= ~crystal_pin_a;
    // external oscillator runs free, usable at once
    if (!ext_enable)
      ext_clock_pin <= 1'b0;
    else if (cnt_q == 0)
      ext_clock_pin <= ~ext_clock_pin;
  end
endmodule

// [test/cgs_clock_gen_monitor.sv]
`timescale 1ns/1ns
module cgs_clock_gen_monitor #(
  parameter VSTAB_CYC    = 50,
  parameter FASTRISE_CYC = 20
) (
  // clock and reset
  input  wire clock,
  input  wire rst,
  // options and supply
  input  wire por_threshold_option,
  input  wire wdt_enable_opt,
  input  wire supply_above_low,
  // standby and pins
  input  wire stop_exec,
  input  wire standby,
  input  wire osc_amp_enable,
  input  wire crystal_pin_a_port_mode,
  input  wire crystal_pin_b_port_mode,
  // clock enables
  input  wire internal_reset,
  input  wire hs_int_tick,
  input  wire hs_sys_clk_tick,
  input  wire main_tick,
  input  wire cpu_tick_q,
  input  wire wdt_tick,
  input  wire cpu_on_hs
);
  reg [19:0] sup_cnt_q;
  // cycles since supply passed the low threshold
  always @(posedge clock or posedge rst)
    if (rst)
      sup_cnt_q <= 20'h0;
    else if (!supply_above_low)
      sup_cnt_q <= 20'h0;
    else if (sup_cnt_q != 20'hfffff)
      sup_cnt_q <= sup_cnt_q + 20'h1;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_stop_req;
    stop_exec;
  endsequence
  sequence s_halted;
    standby && !osc_amp_enable;
  endsequence
  AST_PORT_IO_RESET: assert property ($past(rst) |-> crystal_pin_a_port_mode && crystal_pin_b_port_mode)
    else $error("pins not in port mode after reset");
  AST_WDT_GATE: assert property (wdt_tick |-> wdt_enable_opt)
    else $error("watchdog tick while disabled");
  AST_PRESCALE: assert property (cpu_tick_q |-> $past(main_tick))
    else $error("cpu tick without main tick");
  AST_NO_CPU_IN_RESET: assert property ($past(internal_reset) |-> !cpu_tick_q)
    else $error("cpu tick during internal reset");
  AST_STOP_ENTER: assert property (s_stop_req |=> s_halted)
    else $error("stop did not halt oscillator");
  AST_STOP_QUIET: assert property (standby && $past(standby) |-> !hs_int_tick && !hs_sys_clk_tick)
    else $error("high-speed tick in standby");
  AST_SWITCH_MUTE: assert property ($changed(cpu_on_hs) |-> !main_tick)
    else $error("main tick at source switch");
  AST_SUPPLY_HOLD: assert property (!supply_above_low |-> ##[1:2] internal_reset)
    else $error("no reset with supply low");
  AST_VSTAB: assert property ($fell(internal_reset) |-> (sup_cnt_q >= VSTAB_CYC - 2)
    || (por_threshold_option && sup_cnt_q >= FASTRISE_CYC - 2))
    else $error("reset released before supply wait");
endmodule
bind cgs_clock_gen cgs_clock_gen_monitor #(.VSTAB_CYC(VSTAB_CYC), .FASTRISE_CYC(FASTRISE_CYC)) u_mon (
  .clock(clock), .rst(rst), .por_threshold_option(por_threshold_option),
  .wdt_enable_opt(wdt_enable_opt), .supply_above_low(supply_above_low), .stop_exec(stop_exec),
  .standby(standby), .osc_amp_enable(osc_amp_enable),
  .crystal_pin_a_port_mode(crystal_pin_a_port_mode),
  .crystal_pin_b_port_mode(crystal_pin_b_port_mode), .internal_reset(internal_reset),
  .hs_int_tick(hs_int_tick), .hs_sys_clk_tick(hs_sys_clk_tick), .main_tick(main_tick),
  .cpu_tick_q(cpu_tick_q), .wdt_tick(wdt_tick), .cpu_on_hs(cpu_on_hs));

// [test/cgs_clock_gen_test.sv]
`timescale 1ns/1ns
`define CGS_CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
`define CGS_RANGE(nm, v, lo, hi) `CGS_CHECK(nm, 1'b1, ((v) >= (lo) && (v) <= (hi)))
module cgs_clock_gen_test;
  reg        clock, rst, reg_wr, reg_rd, por_opt, lsi_opt, wdt_opt, sup_lo, sup_hi;
  reg        stop_exec, stop_wake, ext_en;
  reg  [3:0] reg_addr;
  reg  [7:0] reg_wdata, rd_q, e;
  wire [7:0] reg_rdata;
  wire [4:0] periph;
  wire       standby, pa, pb, amp, int_rst, hsi, hsys, main_tick, cpu_tick, wdt, t8, on_hs;
  wire       xa, xe;
  integer    errors, check_count, i, n_hsi, n_lsi, n_wdt, n_main, n_cpu, n_p16;
  localparam [27:0] RA = 28'hf543210;
  localparam [55:0] RV = 56'h00020005008000;
  cgs_clock_gen #(.VSTAB_CYC(50), .FASTRISE_CYC(20)) DUT (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por_threshold_option(por_opt),
    .lowspeed_stoppable_opt(lsi_opt), .wdt_enable_opt(wdt_opt), .supply_above_low(sup_lo),
    .supply_above_high(sup_hi), .stop_exec(stop_exec), .stop_wake(stop_wake),
    .standby(standby), .crystal_pin_a(xa), .ext_clock_pin(xe), .crystal_pin_a_port_mode(pa),
    .crystal_pin_b_port_mode(pb), .osc_amp_enable(amp), .internal_reset(int_rst),
    .hs_int_tick(hsi), .hs_sys_clk_tick(hsys), .main_tick(main_tick), .cpu_tick_q(cpu_tick),
    .periph_tick_q(periph), .wdt_tick(wdt), .timer8_tick(t8), .cpu_on_hs(on_hs));
  cgs_clock_source #(.HALF(2)) u_src (.clock(clock), .osc_amp_enable(amp),
    .ext_enable(ext_en), .crystal_pin_a(xa), .ext_clock_pin(xe));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task end_of_test;
  begin
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task cyc(input integer n);
  begin
    repeat (n) @(posedge clock);
    #1;
  end
  endtask
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  end
  endtask
  task rd_raw(input [3:0] a);
  begin
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  end
  endtask
  task rd(input [3:0] a, input [7:0] x);
  begin
    rd_raw(a);
    `CGS_CHECK("reg_rdata", x, rd_q)
  end
  endtask
  task poll(input [3:0] a, input [7:0] x);
  begin
    rd_raw(a);
    for (i = 0; i < 6000 && rd_q !== x; i = i + 1)
      rd_raw(a);
    `CGS_CHECK("polled reg_rdata", x, rd_q)
    if (rd_q !== x)
      end_of_test;
  end
  endtask
  task count(input integer n);
  begin
    {n_hsi, n_lsi, n_wdt, n_main, n_cpu, n_p16} = 0;
    repeat (n) @(negedge clock)
    begin
      n_p16 = n_p16 + periph[4];
      n_hsi = n_hsi + hsi;
      n_lsi = n_lsi + t8;
      n_wdt = n_wdt + wdt;
      n_main = n_main + main_tick;
      n_cpu = n_cpu + cpu_tick;
    end
  end
  endtask
  task power_up(input integer rise, input integer slow);
  begin
    @(posedge clock);
    rst <= 1'b1;
    sup_lo <= 1'b0;
    sup_hi <= 1'b0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    cyc(rise);
    sup_lo <= 1'b1;
    if (slow)
    begin
      cyc(30);
      `CGS_CHECK("internal_reset", 1'b1, int_rst)
      sup_hi <= 1'b1;
      cyc(2);
      `CGS_CHECK("internal_reset", 1'b0, int_rst)
    end
    else
    begin
      sup_hi <= 1'b1;
      cyc(40 - rise);
      `CGS_CHECK("internal_reset", 1'b1, int_rst)
      cyc(20);
      `CGS_CHECK("internal_reset", 1'b0, int_rst)
    end
  end
  endtask
  initial
  begin
    {rst, reg_wr, reg_rd, por_opt, lsi_opt, wdt_opt, sup_lo, sup_hi} = 8'h80;
    {stop_exec, stop_wake, ext_en, reg_addr, reg_wdata} = 15'h0;
    errors = 0;
    check_count = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    cyc(10);
    `CGS_CHECK("internal_reset", 1'b1, int_rst)
    `CGS_CHECK("port_mode", 2'b11, {pa, pb})
    power_up(0, 0);
    for (i = 0; i < 7; i = i + 1)
      rd(RA[4*i +: 4], RV[8*i +: 8]);
    // stop requests refused on the running cpu clock and locked low-speed clock
    wr(4'h0, 8'h03);
    count(2000);
    `CGS_RANGE("hsi_ticks", n_hsi, 158, 162)
    `CGS_RANGE("main_ticks", n_main, 158, 162)
    `CGS_RANGE("cpu_ticks", n_cpu, 79, 81)
    `CGS_RANGE("periph16_ticks", n_p16, 9, 11)
    `CGS_RANGE("lsi_ticks", n_lsi, 3, 5)
    `CGS_CHECK("wdt_ticks", 0, n_wdt)
    lsi_opt <= 1'b1;
    wr(4'h0, 8'h03);
    count(2000);
    `CGS_CHECK("lsi_ticks", 0, n_lsi)
    `CGS_RANGE("hsi_ticks", n_hsi, 158, 162)
    wr(4'h0, 8'h00);
    wdt_opt <= 1'b1;
    count(2000);
    `CGS_RANGE("wdt_ticks", n_wdt, 3, 5)
    e = 8'h05;
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(4'h3, i[7:0]);
      if (i >= 1 && i <= 5)
        e = i[7:0];
      rd(4'h3, e);
    end
    wr(4'h3, 8'h01);
    wr(4'h4, 8'h01);
    wr(4'h1, 8'h00);
    cyc(2);
    `CGS_CHECK("osc_amp_enable", 1'b1, amp)
    `CGS_CHECK("port_mode", 2'b00, {pa, pb})
    rd(4'h2, 8'h00);
    poll(4'h2, 8'h10);
    wr(4'h4, 8'h03);
    rd(4'h4, 8'h01);
    wr(4'h5, 8'h03);
    poll(4'h5, 8'h83);
    wr(4'h1, 8'h80);
    rd(4'h1, 8'h00);
    wr(4'h0, 8'h01);
    count(2000);
    `CGS_CHECK("hsi_ticks", 0, n_hsi)
    `CGS_RANGE("main_ticks", n_main, 499, 501)
    wr(4'h0, 8'h00);
    @(posedge clock);
    stop_exec <= 1'b1;
    @(posedge clock);
    stop_exec <= 1'b0;
    #1;
    `CGS_CHECK("standby", 1'b1, standby)
    rd(4'h2, 8'h00);
    @(posedge clock);
    stop_wake <= 1'b1;
    @(posedge clock);
    stop_wake <= 1'b0;
    poll(4'h2, 8'h10);
    `CGS_CHECK("standby", 1'b0, standby)
    por_opt <= 1'b1;
    ext_en <= 1'b1;
    power_up(5, 0);
    wr(4'h4, 8'h03);
    wr(4'h1, 8'h00);
    rd(4'h2, 8'h1f);
    `CGS_CHECK("port_mode", 2'b10, {pa, pb})
    wr(4'h5, 8'h03);
    poll(4'h5, 8'h83);
    power_up(0, 1);
    end_of_test;
  end
endmodule
